// file: gpio_exp_pkg.sv
/*
  Constants and state encodings for the 24-pin two-wire I/O expander.
  Assumes a single pclk domain; pins, strap and the two-wire lines arrive asynchronously.
// Notes on behaviour
// - three 8-bit registers per function, 24 pins
// - pins start as inputs, drivers off
// - direction bits steer each pin's direction
// - input holds pin levels, output holds drive values
// - polarity bit set inverts the input value
// - every register reads back its contents
// - power-on reset restores defaults, bus idle
// - reset pin low does the same reinit
// - alert asserted when input differs from held state
// - strap pin sets one slave address bit
// - push-pull pins, drive only when output
// - bus slave works up to fast-mode rate
// - output pins follow output register, inputs float
// - acknowledge own address by pulling data low
*/
package gpio_exp_pkg;
  localparam int NBYTE = 3;
  localparam int NPIN = 8 * NBYTE;
  // fixed upper six bits of the slave address
  localparam logic [5:0] DEV_ADDR_HI = 6'h11;
  // command byte: auto-increment flag, function group, byte index
  localparam int CMD_AI = 7;
  localparam logic [1:0] GRP_IN = 2'h0;
  localparam logic [1:0] GRP_OUT = 2'h1;
  localparam logic [1:0] GRP_POL = 2'h2;
  localparam logic [1:0] GRP_CFG = 2'h3;
  localparam logic [1:0] LAST_BYTE = 2'h2;
  // apb byte offsets
  localparam logic [7:0] A_IN = 8'h00;
  localparam logic [7:0] A_OUT = 8'h04;
  localparam logic [7:0] A_POL = 8'h08;
  localparam logic [7:0] A_CFG = 8'h0C;
  localparam logic [7:0] A_STS = 8'h10;
  localparam logic [7:0] A_MASK = 8'h14;
  localparam logic [7:0] A_FLAGS = 8'h18;
  // interrupt status bits
  localparam int IRQ_CHG = 0;
  localparam int IRQ_WR = 1;
  // values after reset
  localparam logic [23:0] OUT_RST = 24'hFFFFFF;
  localparam logic [23:0] POL_RST = 24'h000000;
  localparam logic [23:0] CFG_RST = 24'hFFFFFF;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [1:0] BOOT_DONE = 2'h3;
  // fast-mode limit and the pclk cycles in its shortest half period
  localparam int PCLK_HZ = 25000000;
  localparam int SCL_MAX_HZ = 400000;
  localparam int SCL_HALF_CYC = PCLK_HZ / (2 * SCL_MAX_HZ);
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_ACK_A = 7'b0000100,
    ST_WRITE = 7'b0001000,
    ST_ACK_W = 7'b0010000,
    ST_READ = 7'b0100000,
    ST_ACK_R = 7'b1000000
  } bus_state_t;
endpackage

// file: i2c_link_if.sv
/*
  Byte-level link between the two-wire slave front end and the register block.
  Assumes both ends run on pclk; strobes are one-cycle pulses.
*/
`timescale 1ns/10ps
interface i2c_link_if;
  logic clear;
  logic addr_low;
  logic wr_stb;
  logic first;
  logic rd_take;
  logic busy;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  modport phy (input clear, addr_low, rd_byte,
    output wr_stb, first, rd_take, busy, wr_byte);
  modport regs (output clear, addr_low, rd_byte,
    input wr_stb, first, rd_take, busy, wr_byte);
endinterface

// file: i2c_byte_slave.sv
/*
  Two-wire slave front end: start/stop detection, address match, byte shifting, acks.
  Assumes scl and sda are asynchronous and the master never stretches or exceeds fast mode.
*/
`timescale 1ns/10ps
module i2c_byte_slave
  import gpio_exp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  i2c_link_if.phy lnk
);
  typedef struct packed {
    bus_state_t st;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rw;
    logic drv;
    logic first;
    logic scl1, scl2, scl3;
    logic sda1, sda2, sda3;
  } phy_t;
  phy_t r, n;
  logic rise, fall, start, stop, match, load;

  // three-stage sampling leaves ample margin in a fast-mode half period
  assign rise = r.scl2 & ~r.scl3;
  assign fall = ~r.scl2 & r.scl3;
  assign start = r.scl2 & r.scl3 & r.sda3 & ~r.sda2;
  assign stop = r.scl2 & r.scl3 & ~r.sda3 & r.sda2;
  // strap supplies the low address bit
  assign match = (r.sh[7:1] == {DEV_ADDR_HI, lnk.addr_low});
  assign load = fall & ((r.st == ST_ACK_A && r.rw) || r.st == ST_ACK_R);
  assign lnk.wr_stb = (r.st == ST_WRITE) & fall & (r.cnt == 4'd8);
  assign lnk.wr_byte = r.sh;
  assign lnk.first = r.first;
  assign lnk.rd_take = load;
  assign lnk.busy = (r.st != ST_IDLE);
  assign sda_out = 1'b0;
  assign sda_oe = r.drv;

  always_comb begin
    n = r;
    n.scl1 = scl_in;
    n.scl2 = r.scl1;
    n.scl3 = r.scl2;
    n.sda1 = sda_in;
    n.sda2 = r.sda1;
    n.sda3 = r.sda2;
    if (lnk.clear || stop) begin
      n.st = ST_IDLE;
      n.drv = 1'b0;
    end else if (start) begin
      n.st = ST_ADDR;
      n.cnt = 4'd0;
      n.drv = 1'b0;
    end else if (load) begin
      n.sh = lnk.rd_byte;
      n.drv = ~lnk.rd_byte[7];
      n.cnt = 4'd0;
      n.st = ST_READ;
    end else begin
      case (r.st)
        ST_IDLE: begin
        end
        ST_ADDR, ST_WRITE: begin
          if (rise) begin
            n.sh = {r.sh[6:0], r.sda2};
            n.cnt = r.cnt + 4'd1;
          end else if (fall && r.cnt == 4'd8) begin
            n.cnt = 4'd0;
            if (r.st == ST_WRITE) begin
              n.drv = 1'b1;
              n.st = ST_ACK_W;
            end else if (match) begin
              n.drv = 1'b1;
              n.rw = r.sh[0];
              n.first = 1'b1;
              n.st = ST_ACK_A;
            end else begin
              n.st = ST_IDLE;
            end
          end
        end
        ST_ACK_A: begin
          if (fall) begin
            n.drv = 1'b0;
            n.st = ST_WRITE;
          end
        end
        ST_ACK_W: begin
          if (fall) begin
            n.drv = 1'b0;
            n.first = 1'b0;
            n.st = ST_WRITE;
          end
        end
        ST_READ: begin
          if (rise) begin
            n.cnt = r.cnt + 4'd1;
          end else if (fall && r.cnt == 4'd8) begin
            n.drv = 1'b0;
            n.st = ST_ACK_R;
          end else if (fall) begin
            n.drv = ~r.sh[6];
            n.sh = {r.sh[6:0], 1'b0};
          end
        end
        ST_ACK_R: begin
          // a not-acknowledge ends the read; wait for stop
          if (rise && r.sda2) begin
            n.st = ST_IDLE;
          end
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.scl1 <= 1'b1;
      r.scl2 <= 1'b1;
      r.scl3 <= 1'b1;
      r.sda1 <= 1'b1;
      r.sda2 <= 1'b1;
      r.sda3 <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_addr_ack;
    ce && !lnk.clear && !start && !stop && r.st == ST_ADDR && fall && r.cnt == 4'd8 && match
      |=> sda_oe && r.st == ST_ACK_A;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");

  property p_addr_other;
    ce && r.st == ST_ADDR && fall && r.cnt == 4'd8 && !match |=> !sda_oe;
  endproperty
  a_addr_other: assert property (p_addr_other)
    else $error("foreign address acknowledged");
endmodule

// file: i2c_gpio_expander_24bit.sv
/*
  Top of the 24-pin expander: pin registers, change alert, apb slave, interrupt logic,
  and the two-wire slave front end.
  Assumes pins, strap, reset pin and two-wire lines are asynchronous to pclk;
  apb master follows the usual setup/access sequence.
*/
`timescale 1ns/10ps
module i2c_gpio_expander_24bit
  import gpio_exp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic rst_pin_n,
  input wire logic addr_strap,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [23:0] pin_in,
  output logic [23:0] pin_out,
  output logic [23:0] pin_oe,
  output logic alert_out,
  output logic alert_oe
);
  typedef struct packed {
    logic [23:0] pin_s1;
    logic [23:0] pin_s2;
    logic rst_s1;
    logic rst_s2;
    logic strap_s1;
    logic strap_s2;
    logic [23:0] outp;
    logic [23:0] pol;
    logic [23:0] cfg;
    logic [23:0] snap;
    logic [1:0] boot;
    logic [7:0] cmd;
    logic [1:0] sts;
    logic [1:0] mask;
    logic alert_q;
    logic [31:0] rdata;
    logic err;
  } regs_t;
  regs_t r, n;
  logic [23:0] live;
  logic [23:0] grp_word;
  logic [1:0] ev;
  logic [1:0] clr;
  logic apb_setup;
  logic apb_wr;
  i2c_link_if lnk ();

  // ---------------------------------------------------------------
  // two-wire front end
  // ---------------------------------------------------------------
  i2c_byte_slave u_phy (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .lnk(lnk.phy)
  );

  // reset pin also returns the bus logic to idle
  assign lnk.clear = ~r.rst_s2;
  // strap is taken live; it must not move inside a frame
  assign lnk.addr_low = r.strap_s2;

  // ---------------------------------------------------------------
  // pin side
  // ---------------------------------------------------------------
  // polarity inversion on the input value
  assign live = r.pin_s2 ^ r.pol;
  // push-pull drive only on output pins
  assign pin_oe = ~r.cfg;
  assign pin_out = r.outp;
  // open drain: never drives high
  assign alert_out = 1'b0;
  assign alert_oe = r.alert_q;
  assign irq = |(r.sts & r.mask);
  assign pready = 1'b1;
  assign prdata = r.rdata;
  assign pslverr = r.err;
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite;

  // ---------------------------------------------------------------
  // read byte for the two-wire side
  // ---------------------------------------------------------------
  // every group reads back
  always_comb begin
    case (r.cmd[3:2])
      GRP_IN: grp_word = live;
      GRP_OUT: grp_word = r.outp;
      GRP_POL: grp_word = r.pol;
      GRP_CFG: grp_word = r.cfg;
      default: grp_word = 24'h000000;
    endcase
    if (r.cmd[1:0] > LAST_BYTE) begin
      lnk.rd_byte = 8'h00;
    end else begin
      lnk.rd_byte = grp_word[{r.cmd[1:0], 3'b000} +: 8];
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n = r;
    clr = 2'h0;
    n.pin_s1 = pin_in;
    n.pin_s2 = r.pin_s1;
    n.rst_s1 = rst_pin_n;
    n.rst_s2 = r.rst_s1;
    n.strap_s1 = addr_strap;
    n.strap_s2 = r.strap_s1;

    // alert while any input differs from its held state
    n.alert_q = (r.boot == BOOT_DONE) & (|((live ^ r.snap) & r.cfg));
    ev = 2'h0;
    ev[IRQ_CHG] = n.alert_q & ~r.alert_q;
    ev[IRQ_WR] = lnk.wr_stb & ~lnk.first;

    // hold state tracks the pins until the synchronisers have filled
    if (r.boot != BOOT_DONE) begin
      n.boot = r.boot + 2'd1;
      n.snap = live;
    end

    if (lnk.wr_stb && lnk.first) begin
      n.cmd = lnk.wr_byte;
    end else if (lnk.wr_stb || lnk.rd_take) begin
      for (int i = 0; i < NBYTE; i++) begin
        if (r.cmd[1:0] == 2'(i)) begin
          if (lnk.wr_stb) begin
            // output, polarity and direction bytes written from the bus
            case (r.cmd[3:2])
              GRP_OUT: n.outp[8*i +: 8] = lnk.wr_byte;
              GRP_POL: n.pol[8*i +: 8] = lnk.wr_byte;
              GRP_CFG: n.cfg[8*i +: 8] = lnk.wr_byte;
              default: n.outp[8*i +: 8] = r.outp[8*i +: 8];
            endcase
          end
          // reading input bytes refreshes held state
          if (lnk.rd_take && r.cmd[3:2] == GRP_IN) begin
            n.snap[8*i +: 8] = live[8*i +: 8];
          end
        end
      end
      if (r.cmd[CMD_AI]) begin
        n.cmd[1:0] = (r.cmd[1:0] >= LAST_BYTE) ? 2'd0 : r.cmd[1:0] + 2'd1;
      end
    end

    // apb read data is latched in the setup cycle, so access is zero-wait
    if (apb_setup) begin
      n.rdata = 32'h00000000;
      n.err = 1'b0;
      case (paddr)
        A_IN: begin
          n.rdata[23:0] = live;
          if (!pwrite) begin
            n.snap = live;
          end
        end
        A_OUT: n.rdata[23:0] = r.outp;
        A_POL: n.rdata[23:0] = r.pol;
        A_CFG: n.rdata[23:0] = r.cfg;
        A_STS: n.rdata[1:0] = r.sts;
        A_MASK: n.rdata[1:0] = r.mask;
        A_FLAGS: n.rdata[1:0] = {lnk.busy, r.alert_q};
        default: n.err = 1'b1;
      endcase
    end

    // apb wins over a two-wire write landing in the same cycle
    if (apb_wr) begin
      case (paddr)
        A_OUT: n.outp = pwdata[23:0];
        A_POL: n.pol = pwdata[23:0];
        A_CFG: n.cfg = pwdata[23:0];
        A_STS: clr = pwdata[1:0];
        A_MASK: n.mask = pwdata[1:0];
        default: n.mask = r.mask;
      endcase
    end

    // a new event beats a clear in the same cycle
    n.sts = (r.sts & ~clr) | ev;

    if (!r.rst_s2) begin
      n.outp = OUT_RST;
      n.pol = POL_RST;
      n.cfg = CFG_RST;
      n.mask = MASK_RST;
      n.sts = 2'h0;
      n.cmd = 8'h00;
      n.boot = 2'h0;
      n.alert_q = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // power-on defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.rst_s1 <= 1'b1;
      r.rst_s2 <= 1'b1;
      r.outp <= OUT_RST;
      r.pol <= POL_RST;
      r.cfg <= CFG_RST;
      r.mask <= MASK_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_boot_inputs;
    !$past(presetn) |-> pin_oe == 24'h000000;
  endproperty
  a_boot_inputs: assert property (p_boot_inputs)
    else $error("driver enabled after reset");

  property p_cfg_write;
    ce && apb_wr && paddr == A_CFG && r.rst_s2 |=> pin_oe == ~$past(pwdata[23:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("direction not applied");

  property p_out_write;
    ce && apb_wr && paddr == A_OUT && r.rst_s2 |=> pin_out == $past(pwdata[23:0]);
  endproperty
  a_out_write: assert property (p_out_write)
    else $error("output drive not applied");

  property p_pol_live;
    (ce && $stable(pin_in) && $stable(r.pol))[*3] |-> live == (pin_in ^ r.pol);
  endproperty
  a_pol_live: assert property (p_pol_live)
    else $error("input value not polarity adjusted");

  property p_cfg_read;
    ce && apb_setup && !pwrite && paddr == A_CFG ##1 psel && penable
      |-> prdata[23:0] == $past(r.cfg);
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("configuration read back wrong");

  property p_alert_set;
    ce && r.boot == BOOT_DONE && r.rst_s2 && |((live ^ r.snap) & r.cfg) |=> alert_oe;
  endproperty
  a_alert_set: assert property (p_alert_set)
    else $error("alert missing on input change");

  property p_alert_clear;
    (ce && $stable(pin_in) && $stable(r.pol))[*3] ##0 apb_setup && !pwrite && paddr == A_IN
      |=> ##1 !alert_oe;
  endproperty
  a_alert_clear: assert property (p_alert_clear)
    else $error("alert not released after input read");

  property p_pin_reset;
    ce && !r.rst_s2 |=> pin_oe == 24'h000000 && pin_out == OUT_RST && !irq;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("reset pin did not restore defaults");

  property p_set_wins;
    ce && r.rst_s2 && ev[IRQ_CHG] && clr[IRQ_CHG] |=> r.sts[IRQ_CHG];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost against clear");

  property p_unmapped;
    ce && apb_setup && paddr > A_FLAGS |=> pslverr && prdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address not refused");
endmodule

// file: i2c_master_model.sv
/*
  Behavioural two-wire bus master driving the expander's serial port.
  Assumes the bench resolves SDA as an open-drain line with a pull-up.
*/
`timescale 1ns/10ps
module i2c_master_model (
  input wire logic clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // quarter of the 320 ns link period
  localparam time Q = 80;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ----------------------------------------
  // frame conditions
  // ----------------------------------------
  // works as a repeated start too: sda released before scl rises
  task automatic start();
    // line changes land on falling pclk edges, away from the sampling edge
    @(negedge clk);
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask
  // scl left high: the clock stands still between frames
  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  // sample in mid-high, well after the slave's late data change
  task automatic clk_bit(input logic b, output logic s);
    #Q sda_low = ~b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
  endtask
  // address and data go out msb first
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(nack, s);
  endtask
endmodule

// file: tb_top.sv
/*
  Self-checking bench for the 24-pin expander: apb master, pins, serial master.
  Assumes the design's assertions sit in its own files; ce drops once to show the freeze.
*/
`timescale 1ns/10ps
module tb_top;
  import gpio_exp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic rst_pin_n = 1'b1;
  logic addr_strap = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [23:0] ext = 24'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, sda_out, sda_oe, alert_out, alert_oe, scl, sda_low, ack;
  logic [23:0] pin_out, pin_oe, m_out, m_pol, m_cfg;
  logic [31:0] d;
  logic [7:0] b0, b1, b2;
  logic e;
  int mismatches = 0;
  int tests_run = 0;
  // pins: design drives where enabled, the outside world elsewhere
  wire logic [23:0] pins = (pin_oe & pin_out) | (~pin_oe & ext);
  wire logic sda = ~(sda_low | (sda_oe & ~sda_out));
  always #20 pclk = ~pclk;
  i2c_gpio_expander_24bit i2c_gpio_expander_24bit_i (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .rst_pin_n(rst_pin_n), .addr_strap(addr_strap), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .pin_in(pins), .pin_out(pin_out),
    .pin_oe(pin_oe), .alert_out(alert_out), .alert_oe(alert_oe));
  i2c_master_model i2c_master_model_i (.clk(pclk), .scl(scl), .sda_low(sda_low), .sda(sda));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // an idle edge first, so psel never gets two assignments in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rv, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a stalled access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, d, e);
    chk(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    apb(1'b1, a, 32'(v), d, e);
  endtask
  function automatic logic [31:0] lvl();
    return 32'((~m_cfg & m_out) | (m_cfg & ext));
  endfunction
  function automatic logic [7:0] sla(input logic s, input logic r);
    return {DEV_ADDR_HI, s, r};
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hEA37DF1A));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(pin_oe), 32'h0);
    rd(A_OUT, 32'(OUT_RST));
    rd(A_POL, 32'(POL_RST));
    rd(A_CFG, 32'(CFG_RST));
    rd(A_MASK, 32'(MASK_RST));
    apb(1'b0, 8'h1C, 32'h0, d, e);
    chk(32'(e), 32'h1);
    $display("test reset done");
    m_cfg = 24'($urandom);
    m_out = 24'($urandom);
    wr(A_CFG, m_cfg);
    wr(A_OUT, m_out);
    @(posedge pclk);
    chk(32'(pin_oe), {8'h00, ~m_cfg});
    chk(32'(pin_out), 32'(m_out));
    rd(A_CFG, 32'(m_cfg));
    rd(A_OUT, 32'(m_out));
    $display("test direction done");
    ext <= 24'($urandom);
    m_pol = 24'($urandom);
    wr(A_POL, m_pol);
    repeat (4) @(posedge pclk);
    rd(A_IN, lvl() ^ 32'(m_pol));
    rd(A_POL, 32'(m_pol));
    $display("test polarity done");
    m_cfg = 24'hFFFFFF;
    wr(A_CFG, m_cfg);
    repeat (4) @(posedge pclk);
    rd(A_IN, lvl() ^ 32'(m_pol));
    wr(A_STS, 24'h3);
    repeat (4) @(posedge pclk);
    chk(32'(alert_oe), 32'h0);
    ext <= ext ^ 24'h800000;
    repeat (6) @(posedge pclk);
    chk(32'(alert_oe), 32'h1);
    rd(A_STS, 32'h1);
    chk(32'(irq), 32'h0);
    wr(A_MASK, 24'h1);
    @(posedge pclk);
    chk(32'(irq), 32'h1);
    ext <= ext ^ 24'h800000;
    repeat (6) @(posedge pclk);
    chk(32'(alert_oe), 32'h0);
    ext <= ext ^ 24'h800000;
    repeat (6) @(posedge pclk);
    rd(A_IN, lvl() ^ 32'(m_pol));
    repeat (3) @(posedge pclk);
    chk(32'(alert_oe), 32'h0);
    wr(A_STS, 24'h1);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    // pin change lands on the clearing write: the status bit must stay set
    ext <= ext ^ 24'h000001;
    wr(A_STS, 24'h1);
    rd(A_STS, 32'h1);
    $display("test alert done");
    // clock enable low freezes synchronisers and alert
    ce <= 1'b0;
    ext <= ext ^ 24'h000001;
    repeat (6) @(posedge pclk);
    chk(32'(alert_oe), 32'h1);
    chk(32'(alert_out), 32'h0);
    ce <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(32'(alert_oe), 32'h0);
    $display("test clock enable done");
    m_cfg = 24'($urandom);
    wr(A_CFG, m_cfg);
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    i2c_master_model_i.start();
    i2c_master_model_i.wbyte(sla(1'b0, 1'b0), ack);
    chk(32'(ack), 32'h1);
    i2c_master_model_i.wbyte(8'h84, ack);
    i2c_master_model_i.wbyte(b0, ack);
    i2c_master_model_i.wbyte(b1, ack);
    i2c_master_model_i.wbyte(b2, ack);
    chk(32'(ack), 32'h1);
    i2c_master_model_i.stop();
    m_out = {b2, b1, b0};
    chk(32'(sda_out), 32'h0);
    repeat (6) @(posedge pclk);
    rd(A_OUT, 32'(m_out));
    chk(32'(pin_out), 32'(m_out));
    apb(1'b0, A_STS, 32'h0, d, e);
    chk(32'(d[1]), 32'h1);
    i2c_master_model_i.start();
    i2c_master_model_i.wbyte(sla(1'b0, 1'b0), ack);
    i2c_master_model_i.wbyte(8'h0C, ack);
    i2c_master_model_i.start();
    i2c_master_model_i.wbyte(sla(1'b0, 1'b1), ack);
    i2c_master_model_i.rbyte(1'b1, b0);
    i2c_master_model_i.stop();
    chk(32'(b0), 32'(m_cfg[7:0]));
    addr_strap <= 1'b1;
    repeat (6) @(posedge pclk);
    i2c_master_model_i.start();
    i2c_master_model_i.wbyte(sla(1'b0, 1'b0), ack);
    i2c_master_model_i.stop();
    chk(32'(ack), 32'h0);
    i2c_master_model_i.start();
    i2c_master_model_i.wbyte(sla(1'b1, 1'b0), ack);
    i2c_master_model_i.stop();
    chk(32'(ack), 32'h1);
    $display("test serial done");
    @(posedge pclk);
    rst_pin_n <= 1'b0;
    repeat (5) @(posedge pclk);
    rst_pin_n <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(32'(pin_oe), 32'h0);
    rd(A_OUT, 32'(OUT_RST));
    rd(A_CFG, 32'(CFG_RST));
    $display("test reset pin done");
    wrap_up();
  end
  // run needs about 1000 cycles; allow ten times that
  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end
endmodule
